// ===== rtl/wdrt_pkg.sv
// package: watchdog reset timer constants and register map
package wdrt_pkg;
  localparam int unsigned WDRT_AW = 12;
  // register byte offsets
  localparam logic [11:0] WDRT_CTRL_OFF = 12'h0d2;
  localparam logic [11:0] WDRT_CTRL_ADDR = 12'h348;
  localparam logic [11:0] WDRT_IRQ_STAT_ADDR = 12'h400;
  localparam logic [11:0] WDRT_IRQ_MASK_ADDR = 12'h404;
  localparam logic [11:0] WDRT_COUNT_ADDR = 12'h408;
  // control field positions
  localparam int unsigned WDRT_DIV_LSB = 0;
  localparam int unsigned WDRT_KICK_BIT = 2;
  localparam int unsigned WDRT_EN_BIT = 3;
  localparam int unsigned WDRT_UNLOCK_BIT = 4;
  // reset values
  localparam logic [1:0] WDRT_DIV_RST = 2'h0;
  localparam logic WDRT_EN_RST = 1'b1;
  localparam logic [7:0] WDRT_CNT_RST = 8'h00;
  // base division exponent, 2^11 = 2048
  localparam int unsigned WDRT_DIV_BASE_EXP = 11;
  localparam int unsigned WDRT_PRE_W = 14;
  localparam int unsigned WDRT_CNT_W = 8;
  // unlock window in system clocks
  localparam int unsigned WDRT_UNLOCK_CLKS = 16;
  localparam logic [4:0] WDRT_UNLOCK_CLKS_V = 5'h10;
  // interrupt status bits
  localparam int unsigned WDRT_IRQ_W = 3;
  localparam int unsigned WDRT_IRQ_KICK = 0;
  localparam int unsigned WDRT_IRQ_HALF = 1;
  localparam int unsigned WDRT_IRQ_LOCKOUT = 2;
  localparam logic [2:0] WDRT_IRQ_RST = 3'h0;
  // system reset pulse length
  localparam logic [3:0] WDRT_RST_PULSE_CLKS = 4'h8;
endpackage

// ===== rtl/wdrt_prescaler.sv
// tick prescaler: pulse once per selected division of the clock
`timescale 1ns/1ps
module wdrt_prescaler
  import wdrt_pkg::*;
#(
  parameter int unsigned PRE_W = WDRT_PRE_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [1:0] div_sel,
  output logic tick
);
  import wdrt_pkg::*;

  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] last_v;

  // terminal count is 2^(11+sel) - 1
  function automatic logic [PRE_W-1:0] term_of(input logic [1:0] sel);
    logic [PRE_W:0] one;
    one = '0;
    one[WDRT_DIV_BASE_EXP + 32'(sel)] = 1'b1;
    return PRE_W'(one - 1'b1);
  endfunction

  assign last_v = term_of(div_sel);
  assign tick = run && (pre_q >= last_v);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (!run || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end
endmodule

// ===== rtl/wdrt_apb_slave.sv
// apb slave front end: single-cycle ready, decode and strobes
`timescale 1ns/1ps
module wdrt_apb_slave
  import wdrt_pkg::*;
(
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [WDRT_AW-1:0] paddr,
  input wire logic [31:0] rdata_mux,
  input wire logic hit,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wr_stb,
  output logic rd_stb
);
  import wdrt_pkg::*;

  assign pready = psel && penable;
  assign pslverr = psel && penable && !hit;
  assign wr_stb = psel && penable && pwrite && hit;
  assign rd_stb = psel && penable && !pwrite && hit;
  assign prdata = (rd_stb) ? rdata_mux : 32'h0000_0000;
endmodule

// ===== rtl/wdrt_top.sv
// watchdog reset timer: control register, counter, unlock and irq
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - 8-bit counter steps on each divided tick; overflow raises system reset.
// - divider field bits 1:0 select division by 2048, 4096, 8192 or 16384.
// - reset interval is 256 times 2^(11+code) system clocks.
// - writing 1 to kick bit 2 clears counter; the bit always reads 0.
// - enable bit 3 is set by every reset; watchdog runs after reset.
// - clearing enable takes effect only within 16 clocks after unlock bit 4 set.
// - writing 1 to enable always enables, no unlock needed.
module wdrt_top
  import wdrt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdrt_pkg::WDRT_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sys_reset_req,
  output logic irq
);
  import wdrt_pkg::*;

  logic [1:0] div_q;
  logic en_q;
  logic unlock_q;
  logic [4:0] win_q;
  logic [7:0] cnt_q;
  logic [3:0] rst_q;
  logic [WDRT_IRQ_W-1:0] stat_q;
  logic [WDRT_IRQ_W-1:0] mask_q;
  logic tick;
  logic wr_stb;
  logic rd_stb;
  logic hit;
  logic [31:0] rdata_mux;
  logic ctrl_wr;
  logic kick;
  logic en_set;
  logic en_clr_req;
  logic en_clr_ok;
  logic overflow;
  logic [WDRT_IRQ_W-1:0] ev;
  logic [7:0] ctrl_view;

  function automatic logic is_reg(input logic [WDRT_AW-1:0] a);
    return (a == WDRT_CTRL_ADDR) || (a == WDRT_IRQ_STAT_ADDR) ||
           (a == WDRT_IRQ_MASK_ADDR) || (a == WDRT_COUNT_ADDR);
  endfunction

  assign hit = is_reg(paddr);

  wdrt_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .rdata_mux(rdata_mux),
    .hit(hit),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb)
  );

  // control writes need byte lane 0
  assign ctrl_wr = wr_stb && (paddr == WDRT_CTRL_ADDR) && pstrb[0];
  assign kick = ctrl_wr && pwdata[WDRT_KICK_BIT];
  assign en_set = ctrl_wr && pwdata[WDRT_EN_BIT];
  assign en_clr_req = ctrl_wr && !pwdata[WDRT_EN_BIT] && en_q;
  // unlock must already be armed from an earlier write
  assign en_clr_ok = en_clr_req && unlock_q && (win_q != 5'h00);

  // kick bit never stored; upper bits zero
  assign ctrl_view = {3'b000, unlock_q, en_q, 1'b0, div_q};

  always_comb begin
    rdata_mux = 32'h0000_0000;
    case (paddr)
      WDRT_CTRL_ADDR: rdata_mux = {24'h000000, ctrl_view};
      WDRT_IRQ_STAT_ADDR: rdata_mux = {29'h0, stat_q};
      WDRT_IRQ_MASK_ADDR: rdata_mux = {29'h0, mask_q};
      WDRT_COUNT_ADDR: rdata_mux = {24'h000000, cnt_q};
      default: rdata_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= WDRT_DIV_RST;
    end else if (ctrl_wr) begin
      div_q <= pwdata[WDRT_DIV_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= WDRT_EN_RST;
    end else if (en_set) begin
      en_q <= 1'b1;
    end else if (en_clr_ok) begin
      en_q <= 1'b0;
    end
  end

  // unlock bit and its 16-clock window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_q <= 1'b0;
      win_q <= 5'h00;
    end else if (ctrl_wr && pwdata[WDRT_UNLOCK_BIT]) begin
      unlock_q <= 1'b1;
      win_q <= WDRT_UNLOCK_CLKS_V;
    end else if (ctrl_wr || win_q == 5'h01) begin
      // any other control write or expiry closes the window
      unlock_q <= 1'b0;
      win_q <= 5'h00;
    end else if (win_q != 5'h00) begin
      win_q <= win_q - 5'h01;
    end
  end

  wdrt_prescaler #(
    .PRE_W(WDRT_PRE_W)
  ) u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(en_q && !kick),
    .div_sel(div_q),
    .tick(tick)
  );

  assign overflow = en_q && tick && (cnt_q == 8'hff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= WDRT_CNT_RST;
    end else if (!en_q || kick) begin
      cnt_q <= WDRT_CNT_RST;
    end else if (tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // stretched reset request toward the system reset controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_q <= 4'h0;
    end else if (overflow) begin
      rst_q <= WDRT_RST_PULSE_CLKS;
    end else if (rst_q != 4'h0) begin
      rst_q <= rst_q - 4'h1;
    end
  end
  assign sys_reset_req = (rst_q != 4'h0);

  // events: kick seen, counter past half, refused disable
  assign ev[WDRT_IRQ_KICK] = kick;
  assign ev[WDRT_IRQ_HALF] = en_q && tick && !kick && (cnt_q == 8'h7f);
  assign ev[WDRT_IRQ_LOCKOUT] = en_clr_req && !en_clr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= WDRT_IRQ_RST;
    end else if (wr_stb && paddr == WDRT_IRQ_STAT_ADDR && pstrb[0]) begin
      stat_q <= (stat_q & ~pwdata[WDRT_IRQ_W-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= WDRT_IRQ_RST;
    end else if (wr_stb && paddr == WDRT_IRQ_MASK_ADDR && pstrb[0]) begin
      mask_q <= pwdata[WDRT_IRQ_W-1:0];
    end
  end

  assign irq = |(stat_q & mask_q);
endmodule

// ===== verif/wdrt_asserts.sv
// checker: watchdog reset timer port assertions
`timescale 1ns/1ps
module wdrt_asserts
  import wdrt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdrt_pkg::WDRT_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sys_reset_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, rc, cw, en_q, unl_q;
  logic [4:0] gap_q;
  assign acc = psel && penable;
  assign rc = acc && !pwrite && paddr == WDRT_CTRL_ADDR;
  assign cw = acc && pwrite && paddr == WDRT_CTRL_ADDR;
  // enable must read one unless a clear followed an unlock closely
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) {en_q, unl_q, gap_q} <= {2'h2, 5'h1f};
    else if (cw) {en_q, unl_q, gap_q} <= {pwdata[3] || (en_q && !(unl_q && gap_q < 5'h10)),
      pwdata[4], 5'h0};
    else if (gap_q != 5'h1f) gap_q <= gap_q + 5'h1;
  property p_ready; pready == acc; endproperty
  property p_idle; !acc |-> prdata == 32'h0; endproperty
  property p_unmap; acc && paddr < 12'h400 && paddr != WDRT_CTRL_ADDR |-> pslverr; endproperty
  property p_map; acc && paddr == WDRT_CTRL_ADDR |-> !pslverr; endproperty
  property p_rsv; rc |-> prdata[7:5] == 3'h0; endproperty
  property p_kick; rc |-> !prdata[2]; endproperty
  property p_en; rc && en_q |-> prdata[3]; endproperty
  property p_pulse; $rose(sys_reset_req) |-> sys_reset_req [*8] ##1 !sys_reset_req; endproperty
  a_ready: assert property (p_ready) else $error("ready");
  a_idle: assert property (p_idle) else $error("idle data");
  a_unmap: assert property (p_unmap) else $error("no error");
  a_map: assert property (p_map) else $error("false error");
  a_rsv: assert property (p_rsv) else $error("reserved");
  a_kick: assert property (p_kick) else $error("kick reads 1");
  a_en: assert property (p_en) else $error("enable lost");
  a_pulse: assert property (p_pulse) else $error("pulse");
  c_kick: cover property (cw && pwdata[2]);
  c_clr: cover property (cw && !pwdata[3]);
  c_err: cover property (acc && pslverr);
endmodule
bind wdrt_top wdrt_asserts chk_u (.*);

// ===== verif/wdrt_tb_top.sv
// testbench: watchdog reset timer over apb
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %0t %h %h", $time, g, e); end end
module wdrt_tb_top;
  import wdrt_pkg::*;
  localparam logic [11:0] ctl = WDRT_CTRL_ADDR, cnt = WDRT_COUNT_ADDR;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, sys_reset_req, irq;
  logic [32:0] ex;
  logic [32:0] expq[$];
  int n_fail = 0, checked = 0;
  wdrt_top dut_u (.*);
  initial forever #20 pclk = ~pclk;
  always @(posedge pclk) if (psel && penable && pready) begin
    ex = expq.pop_front();
    `CHK({pslverr, prdata}, ex)
  end
  task automatic results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] e);
    int n;
    n = 0;
    expq.push_back(e);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n == 50) begin
      n_fail++;
      results();
    end
    {psel, penable} <= 2'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    xfer(1'h0, a, 32'h0, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d, 33'h0);
  endtask
  initial begin
    int r;
    r = $urandom(34);
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    rd(ctl, 33'h8);
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      wr(ctl, (32'(r) & 32'hffffffe0) | 32'hc | 32'(k));
      rd(ctl, 33'h8 | 33'(k));
      rd(cnt, 33'h0);
      repeat ((2048 << k) - 20) @(posedge pclk);
      rd(cnt, 33'h0);
      repeat (12) @(posedge pclk);
      rd(cnt, 33'h1);
    end
    `CHK(sys_reset_req, 1'h0)
    wr(WDRT_IRQ_MASK_ADDR, 32'h4);
    wr(ctl, 32'h0);
    rd(ctl, 33'h8);
    `CHK(irq, 1'h1)
    wr(WDRT_IRQ_STAT_ADDR, 32'h7);
    #1;
    `CHK(irq, 1'h0)
    wr(ctl, 32'h18);
    repeat (20) @(posedge pclk);
    wr(ctl, 32'h0);
    rd(ctl, 33'h8);
    wr(ctl, 32'h18);
    repeat ($urandom % 8) @(posedge pclk);
    wr(ctl, 32'h0);
    rd(ctl, 33'h0);
    repeat (2100) @(posedge pclk);
    rd(cnt, 33'h0);
    `CHK(sys_reset_req, 1'h0)
    wr(ctl, 32'h8);
    rd(ctl, 33'h8);
    xfer(1'h1, 12'h10, 32'hffffffff, 33'h100000000);
    xfer(1'h0, 12'h10, 32'h0, 33'h100000000);
    results();
  end
endmodule
